// ===== core/tdcp_top.sv
// Host byte port block with three down counters and the pacer chain
//
// How it works
// - Base plus zero to three select ports.
// - Bits 7:6 select counter; value three ignored.
// - Bits 5:4 pick low, high, or both bytes.
// - Format zero latches count for stable reads.
// - Two-byte access goes low byte then high.
// - Bits 3:1 choose mode; top ignored modes 2,3.
// - Bit 0 picks binary or decimal counting.
// - Binary spans 65535, decimal spans 9999.
// - Six modes from terminal count to strobes.
// - Counter 0 clock, gate, out on connector.
// - Base defaults to 220 hex, strap may change.
// - Counter 1 output clocks counter 2, pacer.
// - Pacer chain runs from internal 2 MHz.
`timescale 1ns/1ps
module tdcp_top
  import tdcp_pkg::*;
#(
  parameter int MCLK_KHZ_P = MCLK_KHZ,
  parameter int PACER_KHZ_P = PACER_CLK_KHZ
)(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Base address strap
  input wire logic [9:0] base_addr_i,
  // Host byte port
  input wire logic [9:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // Timer connector
  input wire logic timer_connector_clk0_i,
  input wire logic timer_connector_gate0_i,
  input wire logic timer_connector_gate1_i,
  input wire logic timer_connector_gate2_i,
  output logic timer_connector_out0_o,
  output logic timer_connector_out1_o,
  output logic timer_connector_out2_o,
  // Conversion trigger
  output logic ad_pacer_trig_o
);

  localparam int ACC_W = $clog2(MCLK_KHZ_P + 1);
  localparam logic [ACC_W:0] ACC_STEP = (ACC_W + 1)'(PACER_KHZ_P);
  localparam logic [ACC_W:0] ACC_MOD = (ACC_W + 1)'(MCLK_KHZ_P);
  // Idle cycles between pacer ticks: floor and ceiling of the ratio, each less one
  localparam int PACE_MIN = MCLK_KHZ_P / PACER_KHZ_P - 1;
  localparam int PACE_MAX = (MCLK_KHZ_P + PACER_KHZ_P - 1) / PACER_KHZ_P - 1;

  if (PACER_KHZ_P <= 0 || PACER_KHZ_P * 2 > MCLK_KHZ_P) begin : g_chk
    $error("pacer rate must be above zero and at most half of mclk");
  end

  typedef struct packed {
    logic [9:0] base;
    logic base_ok;
    logic [2:0][1:0] fmt;
    logic [2:0] wr_hi;
    logic [2:0] rd_hi;
    logic [2:0] latched;
    logic [2:0][15:0] lat;
    logic [2:0][7:0] lo_stage;
    logic [7:0] rdata;
    logic rvalid;
    logic [ACC_W-1:0] acc;
    logic pace_tick;
    logic clk0_q;
    logic out1_q;
    logic out2_q;
    logic trig;
    logic [ACC_W-1:0] pace_gap;
    logic pace_seen;
  } tdcp_top_s;

  tdcp_top_s s_r;
  tdcp_top_s s_nxt;
  logic [2:0] tick;
  logic [2:0] gate;
  logic [2:0][15:0] cnt_w;
  logic [2:0] out_w;
  logic [2:0] ctrl_wr;
  logic [2:0] load;
  logic [2:0][15:0] load_val;
  logic wr_hit;
  logic rd_hit;
  logic [1:0] off;
  logic [1:0] sel;
  logic [ACC_W:0] acc_sum;

  // Base must sit on a four-port boundary
  function automatic logic port_hit(input logic [9:0] a,
                                    input logic [9:0] b);
    return a[9:2] == b[9:2];
  endfunction

  assign wr_hit = io_wr_i && port_hit(io_addr_i, s_r.base);
  assign rd_hit = io_rd_i && port_hit(io_addr_i, s_r.base);
  assign off = io_addr_i[1:0];
  assign sel = io_wdata_i[COUNTER_SELECT_HI:COUNTER_SELECT_LO];
  assign acc_sum = {1'b0, s_r.acc} + ACC_STEP;

  assign tick[0] = timer_connector_clk0_i && !s_r.clk0_q;
  assign tick[1] = s_r.pace_tick;
  assign tick[2] = out_w[1] && !s_r.out1_q;
  assign gate = {timer_connector_gate2_i, timer_connector_gate1_i,
                 timer_connector_gate0_i};

  always_comb begin
    logic [15:0] src;
    s_nxt = s_r;
    src = COUNT_RESET;
    ctrl_wr = 3'h0;
    load = 3'h0;
    load_val = '0;
    s_nxt.rvalid = 1'b0;
    s_nxt.clk0_q = timer_connector_clk0_i;
    s_nxt.out1_q = out_w[1];
    s_nxt.out2_q = out_w[2];
    s_nxt.trig = out_w[2] && !s_r.out2_q;
    // Strap is caught once, on the first edge after reset release
    if (!s_r.base_ok) begin
      s_nxt.base = base_addr_i;
      s_nxt.base_ok = 1'b1;
    end
    // Fractional divider gives an average 2 MHz count clock
    s_nxt.pace_tick = acc_sum >= ACC_MOD;
    s_nxt.acc = (acc_sum >= ACC_MOD) ? ACC_W'(acc_sum - ACC_MOD)
                                     : ACC_W'(acc_sum);
    // Gap since the last pacer tick, saturating, for the rate check
    if (s_r.pace_tick) begin
      s_nxt.pace_gap = '0;
      s_nxt.pace_seen = 1'b1;
    end else if (s_r.pace_gap != '1) begin
      s_nxt.pace_gap = s_r.pace_gap + ACC_W'(1);
    end
    if (wr_hit && off == COUNTER_CONTROL_BYTE && sel != SEL_ILLEGAL) begin
      if (io_wdata_i[ACCESS_FORMAT_HI:ACCESS_FORMAT_LO] == FMT_LATCH) begin
        if (!s_r.latched[sel]) begin
          s_nxt.latched[sel] = 1'b1;
          s_nxt.lat[sel] = cnt_w[sel];
        end
      end else begin
        ctrl_wr[sel] = 1'b1;
        s_nxt.fmt[sel] = io_wdata_i[ACCESS_FORMAT_HI:ACCESS_FORMAT_LO];
        s_nxt.wr_hi[sel] = 1'b0;
        s_nxt.rd_hi[sel] = 1'b0;
        s_nxt.latched[sel] = 1'b0;
      end
    end else if (wr_hit && off != COUNTER_CONTROL_BYTE) begin
      case (s_r.fmt[off])
        FMT_HIGH: begin
          load[off] = 1'b1;
          load_val[off] = {io_wdata_i, 8'h00};
        end
        FMT_BOTH: begin
          s_nxt.wr_hi[off] = !s_r.wr_hi[off];
          if (s_r.wr_hi[off]) begin
            load[off] = 1'b1;
            load_val[off] = {io_wdata_i, s_r.lo_stage[off]};
          end else begin
            s_nxt.lo_stage[off] = io_wdata_i;
          end
        end
        default: begin
          load[off] = 1'b1;
          load_val[off] = {8'h00, io_wdata_i};
        end
      endcase
    end
    if (rd_hit) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = RDATA_RESET;
      if (off != COUNTER_CONTROL_BYTE) begin
        src = s_r.latched[off] ? s_r.lat[off] : cnt_w[off];
        case (s_r.fmt[off])
          FMT_HIGH: begin
            s_nxt.rdata = src[15:8];
            s_nxt.latched[off] = 1'b0;
          end
          FMT_BOTH: begin
            s_nxt.rdata = s_r.rd_hi[off] ? src[15:8] : src[7:0];
            s_nxt.rd_hi[off] = !s_r.rd_hi[off];
            if (s_r.rd_hi[off]) begin
              s_nxt.latched[off] = 1'b0;
            end
          end
          default: begin
            s_nxt.rdata = src[7:0];
            s_nxt.latched[off] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{base: BASE_ADDR_DEFAULT, fmt: {3{FMT_RESET}},
               lat: '0, lo_stage: '0, rdata: RDATA_RESET, acc: '0,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    tdcp_counter u_cnt (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick[i]),
      .gate_i(gate[i]),
      .ctrl_wr_i(ctrl_wr[i]),
      .ctrl_mode_i(io_wdata_i[OP_MODE_BIT2:OP_MODE_BIT0]),
      .ctrl_bcd_i(io_wdata_i[DECIMAL_POS]),
      .load_i(load[i]),
      .load_val_i(load_val[i]),
      .count_o(cnt_w[i]),
      .out_o(out_w[i])
    );
  end

  assign io_rdata_o = s_r.rdata;
  assign io_rvalid_o = s_r.rvalid;
  assign timer_connector_out0_o = out_w[0];
  assign timer_connector_out1_o = out_w[1];
  assign timer_connector_out2_o = out_w[2];
  assign ad_pacer_trig_o = s_r.trig;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  wire ctl_wr = wr_hit && off == COUNTER_CONTROL_BYTE;
  sequence lo_wr1;
    wr_hit && off == COUNTER_ONE_DATA && s_r.fmt[1] == FMT_BOTH &&
      !s_r.wr_hi[1];
  endsequence
  sequence hi_wr1;
    wr_hit && off == COUNTER_ONE_DATA && s_r.wr_hi[1];
  endsequence

  illegal_sel_a: assert property (ctl_wr && sel == SEL_ILLEGAL
    |=> $stable(s_r.fmt) && $stable(s_r.latched))
    else $error("illegal select acted");
  ctrl_fmt_a: assert property (ctl_wr && sel == 2'h1 &&
    io_wdata_i[5:4] != FMT_LATCH |=> s_r.fmt[1] == $past(io_wdata_i[5:4]))
    else $error("format not stored");
  latch_cap_a: assert property (ctl_wr && sel == 2'h0 &&
    io_wdata_i[5:4] == FMT_LATCH && !s_r.latched[0]
    |=> s_r.latched[0] && s_r.lat[0] == $past(cnt_w[0]))
    else $error("latch missed");
  pair_low_a: assert property (lo_wr1 |=> s_r.wr_hi[1] &&
    s_r.lo_stage[1] == $past(io_wdata_i)) else $error("low byte lost");
  pair_high_a: assert property (hi_wr1 |-> load[1] &&
    load_val[1] == {io_wdata_i, s_r.lo_stage[1]})
    else $error("pair load wrong");
  rd_high_a: assert property (rd_hit && off == COUNTER_TWO_DATA &&
    s_r.fmt[2] == FMT_HIGH && !s_r.latched[2]
    |=> io_rvalid_o && io_rdata_o == $past(cnt_w[2][15:8]))
    else $error("read data wrong");
  pacer_rate_a: assert property (s_r.pace_tick && s_r.pace_seen
    |-> s_r.pace_gap >= PACE_MIN && s_r.pace_gap <= PACE_MAX)
    else $error("pacer rate off");
  pacer_gap_a: assert property (s_r.pace_seen
    |-> s_r.pace_gap <= PACE_MAX) else $error("pacer tick missing");
  chain_trig_a: assert property (out_w[2] && !s_r.out2_q
    |=> ad_pacer_trig_o ##1 !ad_pacer_trig_o) else $error("no trigger");
  base_cap_a: assert property ($rose(s_r.base_ok)
    |-> s_r.base == $past(base_addr_i)) else $error("strap not caught");

endmodule

// ===== core/tdcp_pkg.sv
// Shared constants, types and decoding helpers of the down counter block
package tdcp_pkg;

  // ****************************************
  // Port offsets and base address
  // ****************************************
  localparam logic [1:0] COUNTER_ZERO_DATA = 2'h0;
  localparam logic [1:0] COUNTER_ONE_DATA = 2'h1;
  localparam logic [1:0] COUNTER_TWO_DATA = 2'h2;
  localparam logic [1:0] COUNTER_CONTROL_BYTE = 2'h3;
  localparam logic [9:0] BASE_ADDR_DEFAULT = 10'h220;

  // ****************************************
  // Control byte fields
  // ****************************************
  localparam int COUNTER_SELECT_HI = 7;
  localparam int COUNTER_SELECT_LO = 6;
  localparam int ACCESS_FORMAT_HI = 5;
  localparam int ACCESS_FORMAT_LO = 4;
  localparam int OP_MODE_BIT2 = 3;
  localparam int OP_MODE_BIT0 = 1;
  localparam int DECIMAL_POS = 0;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW = 2'h1;
  localparam logic [1:0] FMT_HIGH = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;

  // ****************************************
  // Reset values and rates
  // ****************************************
  localparam logic [1:0] FMT_RESET = FMT_LOW;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam int MCLK_KHZ = 25000;
  localparam int PACER_CLK_KHZ = 2000;

  typedef enum logic [2:0] {
    MODE_TC_EVENT, MODE_ONE_SHOT, MODE_RATE,
    MODE_SQUARE, MODE_SW_STROBE, MODE_HW_STROBE
  } tdcp_mode_e;

  function automatic tdcp_mode_e tdcp_decode_mode(input logic [2:0] m);
    case (m)
      3'h0: return MODE_TC_EVENT;
      3'h1: return MODE_ONE_SHOT;
      3'h4: return MODE_SW_STROBE;
      3'h5: return MODE_HW_STROBE;
      default: return m[0] ? MODE_SQUARE : MODE_RATE;
    endcase
  endfunction

  // One step down, binary or four decimal digits
  function automatic logic [15:0] tdcp_dec(input logic [15:0] v,
                                            input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      for (int i = 0; i < 4; i++) begin
        r[4*i +: 4] = v[4*i +: 4];
        if (borrow) begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

endpackage

// ===== core/tdcp_counter.sv
// One 16-bit down counter with its six output modes
`timescale 1ns/1ps
module tdcp_counter
  import tdcp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Count clock and gate
  input wire logic tick_i,
  input wire logic gate_i,
  // Programming from the port side
  input wire logic ctrl_wr_i,
  input wire logic [2:0] ctrl_mode_i,
  input wire logic ctrl_bcd_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  // State
  output logic [15:0] count_o,
  output logic out_o
);

  typedef struct packed {
    tdcp_mode_e mode;
    logic bcd;
    logic [15:0] init;
    logic [15:0] cnt;
    logic loaded;
    logic pend;
    logic run;
    logic trig;
    logic gate_q;
    logic out;
  } tdcp_cnt_s;

  tdcp_cnt_s s_r;
  tdcp_cnt_s s_nxt;
  logic [15:0] dec1;
  logic [15:0] dec2;
  logic [15:0] half;

  assign dec1 = tdcp_dec(s_r.cnt, s_r.bcd);
  assign dec2 = tdcp_dec(dec1, s_r.bcd);
  // Odd counts in square mode run both halves at count minus one
  assign half = {s_r.init[15:1], 1'b0};

  always_comb begin
    s_nxt = s_r;
    s_nxt.gate_q = gate_i;
    if (ctrl_wr_i) begin
      s_nxt.mode = tdcp_decode_mode(ctrl_mode_i);
      s_nxt.bcd = ctrl_bcd_i;
      s_nxt.loaded = 1'b0;
      s_nxt.pend = 1'b0;
      s_nxt.run = 1'b0;
      s_nxt.trig = 1'b0;
      s_nxt.out = (tdcp_decode_mode(ctrl_mode_i) != MODE_TC_EVENT);
    end else if (load_i) begin
      s_nxt.init = load_val_i;
      s_nxt.loaded = 1'b1;
      s_nxt.pend = 1'b1;
      s_nxt.trig = 1'b0;
      if (s_r.mode == MODE_TC_EVENT) begin
        s_nxt.out = 1'b0;
      end
    end else if (tick_i) begin
      s_nxt.trig = 1'b0;
      s_nxt.pend = 1'b0;
      case (s_r.mode)
        MODE_TC_EVENT: begin
          if (s_r.pend) begin
            s_nxt.cnt = s_r.init;
            s_nxt.run = 1'b1;
          end else if (s_r.run && gate_i) begin
            s_nxt.cnt = dec1;
            if (s_r.cnt == 16'h0001) begin
              s_nxt.out = 1'b1;
            end
          end
        end
        MODE_ONE_SHOT: begin
          if (s_r.trig && s_r.loaded) begin
            s_nxt.cnt = s_r.init;
            s_nxt.run = 1'b1;
            s_nxt.out = 1'b0;
          end else if (s_r.run) begin
            s_nxt.cnt = dec1;
            if (s_r.cnt == 16'h0001) begin
              s_nxt.out = 1'b1;
              s_nxt.run = 1'b0;
            end
          end
        end
        MODE_RATE, MODE_SQUARE: begin
          if ((s_r.pend || s_r.trig) && s_r.loaded) begin
            s_nxt.cnt = (s_r.mode == MODE_RATE) ? s_r.init : half;
            s_nxt.run = 1'b1;
            s_nxt.out = 1'b1;
          end else if (s_r.run && gate_i) begin
            if (s_r.mode == MODE_SQUARE) begin
              s_nxt.cnt = (s_r.cnt == 16'h0002) ? half : dec2;
              if (s_r.cnt == 16'h0002) begin
                s_nxt.out = !s_r.out;
              end
            end else if (s_r.cnt == 16'h0001) begin
              s_nxt.cnt = s_r.init;
              s_nxt.out = 1'b1;
            end else begin
              s_nxt.cnt = dec1;
              s_nxt.out = (s_r.cnt != 16'h0002);
            end
          end
        end
        MODE_SW_STROBE, MODE_HW_STROBE: begin
          if ((s_r.mode == MODE_SW_STROBE) ? s_r.pend
              : (s_r.trig && s_r.loaded)) begin
            s_nxt.cnt = s_r.init;
            s_nxt.run = 1'b1;
            s_nxt.out = 1'b1;
          end else if (s_r.run && (gate_i ||
                       s_r.mode == MODE_HW_STROBE)) begin
            s_nxt.cnt = dec1;
            if (s_r.cnt == 16'h0001) begin
              s_nxt.out = 1'b0;
              s_nxt.run = 1'b0;
            end
          end else begin
            s_nxt.out = 1'b1;
          end
        end
        default: s_nxt.run = 1'b0;
      endcase
    end
    // A gate edge arriving as a trigger is consumed is kept
    if (gate_i && !s_r.gate_q && !ctrl_wr_i) begin
      s_nxt.trig = 1'b1;
    end
    if (!gate_i && (s_r.mode == MODE_RATE || s_r.mode == MODE_SQUARE)) begin
      s_nxt.out = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{mode: MODE_TC_EVENT, bcd: 1'b0, init: COUNT_RESET,
               cnt: COUNT_RESET, out: 1'b0, default: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_o = s_r.cnt;
  assign out_o = s_r.out;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  wire quiet = !ctrl_wr_i && !load_i;

  ctrl_halt_a: assert property (ctrl_wr_i ##1 (!load_i)[*2]
    |-> $stable(count_o)) else $error("count moved before reload");
  gate_hold_a: assert property (s_r.mode == MODE_TC_EVENT &&
    !gate_i && quiet && !s_r.pend |=> $stable(count_o))
    else $error("count moved with gate low");
  tc_out_a: assert property (s_r.mode == MODE_TC_EVENT &&
    s_r.run && gate_i && tick_i && quiet && s_r.cnt == 16'h0001
    |=> out_o && count_o == 16'h0000) else $error("terminal out late");
  bcd_wrap_a: assert property (s_r.mode == MODE_TC_EVENT &&
    s_r.bcd && s_r.run && gate_i && tick_i && quiet &&
    s_r.cnt == 16'h0000 |=> count_o == 16'h9999)
    else $error("decimal wrap wrong");
  mode_dec_a: assert property (ctrl_wr_i && ctrl_mode_i == 3'h6
    |=> s_r.mode == MODE_RATE) else $error("mode decode wrong");
  rate_gate_a: assert property (s_r.mode == MODE_RATE &&
    !gate_i && !ctrl_wr_i |=> out_o) else $error("rate out low");

endmodule

// ===== sim/tdcp_host_model.sv
// Host processor model driving the byte wide I/O port of the block
`timescale 1ns/1ps
module tdcp_host_model (
  // Clock
  input wire logic mclk_i,
  // Host byte port
  output logic [9:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    io_addr_o = 10'h000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end

  // Released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge mclk_i);
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge mclk_i);
    io_addr_o <= a;
    io_rd_o <= 1'b1;
    @(posedge mclk_i);
    io_rd_o <= 1'b0;
    io_addr_o <= ~a;
  endtask

  // Two byte transfers always go low byte first, then high byte
  task automatic wr16(input logic [9:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask

  task automatic rd2(input logic [9:0] a);
    rd(a);
    rd(a);
  endtask
endmodule

// ===== sim/tdcp_top_tb.sv
// Self-checking bench of the triple down counter port block
`timescale 1ns/1ps
module tdcp_top_tb;
  import tdcp_pkg::*;
  localparam logic [9:0] BASE = BASE_ADDR_DEFAULT;
  localparam int LIMIT = 10000;
  localparam int WIN = 2000;
  logic mclk_i;
  logic rst_i;
  logic [9:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata_o;
  logic io_rvalid_o;
  logic clk0;
  logic gate0;
  logic gate1;
  logic gate2;
  logic out0;
  logic out1;
  logic out2;
  logic trig;
  logic [7:0] v;
  logic [7:0] e;
  logic [7:0] exp_q[$];
  int failures = 0;
  int checked = 0;
  int seed = 37;
  int cycles = 0;
  int trigs = 0;
  int want;
  int rises1 = 0;
  int rises2 = 0;
  logic out1_q;
  logic out2_q;
  logic [9:0] strap;

  // ****************************************
  // Design and host
  // ****************************************
  tdcp_top #(.MCLK_KHZ_P(MCLK_KHZ), .PACER_KHZ_P(PACER_CLK_KHZ)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .base_addr_i(strap),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .timer_connector_clk0_i(clk0),
    .timer_connector_gate0_i(gate0), .timer_connector_gate1_i(gate1),
    .timer_connector_gate2_i(gate2), .timer_connector_out0_o(out0),
    .timer_connector_out1_o(out1), .timer_connector_out2_o(out2),
    .ad_pacer_trig_o(trig)
  );

  tdcp_host_model host (
    .mclk_i(mclk_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata)
  );

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic push16(input logic [15:0] x);
    exp_q.push_back(x[7:0]);
    exp_q.push_back(x[15:8]);
  endtask

  // Count clock edges are spaced well apart so each is seen once
  task automatic tick0(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      clk0 <= 1'b1;
      idle(3);
      clk0 <= 1'b0;
      idle(3);
    end
  endtask

  // ****************************************
  // Read watcher and timeout
  // ****************************************
  always @(posedge mclk_i) begin
    cycles++;
    if (io_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("stray rvalid", 16'h0001, 16'h0000);
      end else begin
        check("rdata", {8'h00, io_rdata_o}, {8'h00, exp_q.pop_front()});
      end
    end
    if (trig === 1'b1) begin
      trigs++;
    end
    if (out1 === 1'b1 && out1_q === 1'b0) begin
      rises1++;
    end
    if (out2 === 1'b1 && out2_q === 1'b0) begin
      rises2++;
    end
    out1_q = out1;
    out2_q = out2;
    if (cycles == LIMIT) begin
      failures++;
      end_of_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    clk0 = 1'b0;
    gate0 = 1'b1;
    gate1 = 1'b1;
    gate2 = 1'b1;
    strap = BASE;
    repeat (16) @(posedge mclk_i);
    check("reset state", {3'h0, io_rdata_o, io_rvalid_o, out0, out1, out2,
          trig}, 16'h0000);
    rst_i <= 1'b0;
    idle(2);
    exp_q.push_back(8'h00);
    host.rd(BASE + 10'h3);
    exp_q.push_back(8'h00);
    host.rd(BASE);
    host.rd(BASE + 10'h4);
    // Mode 0, both bytes, latched read with a tick in between
    host.wr(BASE + 10'h3, 8'h30);
    host.wr16(BASE, 16'h0003);
    host.wr(BASE + 10'h7, 8'h20);
    tick0(2);
    check("out0 counting", {15'h0, out0}, 16'h0000);
    push16(16'h0002);
    host.wr(BASE + 10'h3, 8'h00);
    tick0(1);
    host.rd2(BASE);
    tick0(1);
    check("out0 terminal", {15'h0, out0}, 16'h0001);
    // Wrap below zero in binary and decimal style
    for (int b = 0; b < 2; b++) begin
      host.wr(BASE + 10'h3, {7'h18, b[0]});
      host.wr16(BASE, 16'h0000);
      tick0(2);
      push16(b == 1 ? 16'h9999 : 16'hffff);
      host.wr(BASE + 10'h3, 8'h00);
      host.rd2(BASE);
    end
    // Every mode code, gate pulsed first to start the triggered modes
    for (int m = 0; m < 8; m++) begin
      v = (8'($random(seed)) & 8'hfe) | 8'h10;
      host.wr(BASE + 10'h3, {4'h1, m[2:0], 1'b0});
      host.wr(BASE, v);
      gate0 <= 1'b0;
      idle(3);
      gate0 <= 1'b1;
      idle(3);
      tick0(3);
      e = v - ((m[1:0] == 2'b11) ? 8'h04 : 8'h02);
      exp_q.push_back(e);
      host.rd(BASE);
    end
    // Control write halts; illegal select must not touch counter 0
    host.wr(BASE + 10'h3, 8'h10);
    tick0(2);
    host.wr(BASE + 10'h3, 8'he4);
    exp_q.push_back(e);
    host.rd(BASE);
    // High byte only format
    v = 8'($random(seed));
    host.wr(BASE + 10'h3, 8'h20);
    host.wr(BASE, v);
    tick0(1);
    // Gate low must hold the count through further ticks
    gate0 <= 1'b0;
    tick0(2);
    gate0 <= 1'b1;
    exp_q.push_back(v);
    host.rd(BASE);
    // Pacer chain, both counters divide by two in rate mode
    host.wr(BASE + 10'h3, 8'h74);
    host.wr16(BASE + 10'h1, 16'h0002);
    host.wr(BASE + 10'h3, 8'hb4);
    host.wr16(BASE + 10'h2, 16'h0002);
    idle(100);
    trigs = 0;
    rises1 = 0;
    rises2 = 0;
    idle(WIN);
    want = WIN * PACER_CLK_KHZ / MCLK_KHZ / 4;
    check("pacer rate", {15'h0, trigs >= want - 2 && trigs <= want + 2},
          16'h0001);
    check("out1 edges", {15'h0, rises1 >= 2 * want - 2 &&
          rises1 <= 2 * want + 2}, 16'h0001);
    check("out2 edges", {15'h0, rises2 >= trigs - 1 &&
          rises2 <= trigs + 1}, 16'h0001);
    // Counter 2 high byte read, held by its gate after the load
    gate2 <= 1'b0;
    host.wr(BASE + 10'h3, 8'ha0);
    host.wr(BASE + 10'h2, 8'h5a);
    idle(60);
    exp_q.push_back(8'h5a);
    host.rd(BASE + 10'h2);
    gate2 <= 1'b1;
    idle(2);
    // Second reset with a moved strap; the old base must fall silent
    strap <= 10'h300;
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(2);
    exp_q.push_back(8'h00);
    host.rd(10'h303);
    exp_q.push_back(8'h00);
    host.rd(10'h300);
    host.rd(BASE + 10'h3);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) begin
      @(posedge mclk_i);
    end
    check("reads pending", 16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
